// ---- rtl/asmu_cmp.sv ----
// asmu_cmp: registered comparator of the per-channel phase accumulators
// assumes both channel accumulator sets are already on sys_clk
`timescale 1ns/100ps
module asmu_cmp
  import asmu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ASMU_NACC-1:0][31:0] acc_a,
  input wire logic [ASMU_NACC-1:0][31:0] acc_b,
  output logic mismatch
);
  logic [ASMU_NACC-1:0] diff;
  // one compare per accumulator pair
  genvar g;
  generate
    for (g = 0; g < ASMU_NACC; g++) begin : g_acc
      assign diff[g] = acc_a[g] != acc_b[g];
    end
  endgenerate
  // registered so the wide compare does not stretch the flag path
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mismatch <= 1'b0;
    end else begin
      mismatch <= |diff;
    end
  end
endmodule

// ---- rtl/asmu_pkg.sv ----
// asmu_pkg: register map, field positions and carrier types for the alarm unit
// assumes one 100 MHz internal digital clock and a byte-wide register port
package asmu_pkg;
  localparam int ASMU_AW = 12;
  localparam logic [11:0] ASMU_ADDR_SUMMARY = 12'h2C0;
  localparam logic [11:0] ASMU_ADDR_FLAGS = 12'h2C1;
  localparam logic [11:0] ASMU_ADDR_MASK = 12'h2C2;
  localparam logic [4:0] ASMU_FLAGS_RST = 5'h1F;
  localparam logic [4:0] ASMU_MASK_RST = 5'h1F;
  localparam int ASMU_BIT_PLL = 4;
  localparam int ASMU_BIT_LINK = 3;
  localparam int ASMU_BIT_REALIGN = 2;
  localparam int ASMU_BIT_NCO = 1;
  localparam int ASMU_BIT_DIV = 0;
  localparam int ASMU_NALM = 5;
  localparam int ASMU_NACC = 4;
  localparam logic [1:0] ASMU_PINSEL_ALARM = 2'h1;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } asmu_req_t;

  // raw conditions from the surrounding converter logic
  typedef struct packed {
    logic pll_locked;
    logic link_enable_ctrl;
    logic data_encoding_state;
    logic sysref_realign;
    logic nco_sync;
    logic [ASMU_NACC-1:0][31:0] acc_a;
    logic [ASMU_NACC-1:0][31:0] acc_b;
    logic [7:0] div_a;
    logic [7:0] div_b;
  } asmu_cond_t;
endpackage

// ---- rtl/asmu_top.sv ----
// asmu_top: sticky alarm flags, mask, summary alarm and status pin routing
// assumes the register port and all condition inputs are on sys_clk,
// except pll_locked which comes from the analog PLL and is synchronised here
//
// Summary of operation
// (R1) the PLL flag at bit 4 is set whenever the PLL is out of lock.
// (R2) the link flag at bit 3 is set while the link is enabled but not in data encoding.
// (R3) the realign flag at bit 2 is set when a SYSREF event realigns the internal clocks.
// (R4) the NCO flag at bit 1 is set on NCO synchronisation or while the link is disabled.
// (R5) the NCO flag is also set when any channel A accumulator differs from channel B.
// (R6) the divider flag at bit 0 is set when the channel A and B dividers disagree.
// (R7) each flag stays set until software writes a one to its bit; a zero leaves it.
// (R8) the mask register sits at 0x2C2, resets to 0x1F, bits 7 to 5 reserved.
// (R9) a set mask bit keeps its flag out of the summary but the flag still records.
// (R10) the summary bit at 0x2C0 bit 0 is one when any unmasked flag is set; read only.
// (R11) when the pin select picks it, the summary drives the calibration status pin.
// (R12) the flag register sits at 0x2C1 and resets to 0x1F.
// (R13) a set condition in the same cycle as a write-one clear leaves the flag set.
// (R14) reserved bits 7 to 5 of both registers read zero and ignore writes.
`timescale 1ns/100ps
module asmu_top
  import asmu_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input asmu_pkg::asmu_req_t req,
  input asmu_pkg::asmu_cond_t cond,
  input wire logic [1:0] status_pin_select,
  output logic [7:0] rdata,
  output logic calibration_status_pin
);
  import asmu_pkg::*;

  typedef struct packed {
    logic [1:0] lock_sync;
    logic [4:0] alarm_flags;
    logic [4:0] alarm_enable_mask;
    logic summary;
    logic [7:0] rdata;
    logic pin;
  } asmu_state_t;

  asmu_state_t st_r;
  asmu_state_t st_nxt;
  logic acc_mismatch;
  logic [4:0] set_vec;
  logic [4:0] clr_vec;
  logic [4:0] flags_new;
  logic [4:0] mask_new;

  asmu_cmp u_cmp (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .acc_a(cond.acc_a),
    .acc_b(cond.acc_b),
    .mismatch(acc_mismatch)
  );

  // set conditions, one per flag
  always_comb begin
    set_vec = '0;
    set_vec[ASMU_BIT_PLL] = ~st_r.lock_sync[1]; // R1
    set_vec[ASMU_BIT_LINK] = cond.link_enable_ctrl & ~cond.data_encoding_state; // R2
    set_vec[ASMU_BIT_REALIGN] = cond.sysref_realign; // R3
    set_vec[ASMU_BIT_NCO] = cond.nco_sync | ~cond.link_enable_ctrl // R4
      | acc_mismatch; // R5
    set_vec[ASMU_BIT_DIV] = cond.div_a != cond.div_b; // R6
  end

  // next state: sticky flags, mask, summary, read data
  always_comb begin
    st_nxt = st_r;
    // second stage is the only reader of the first
    st_nxt.lock_sync = {st_r.lock_sync[0], cond.pll_locked};
    clr_vec = (req.wr && req.addr == ASMU_ADDR_FLAGS) ? req.wdata[4:0] : 5'h00; // R7 R14
    flags_new = (st_r.alarm_flags & ~clr_vec) | set_vec; // R7 R13
    st_nxt.alarm_flags = flags_new;
    mask_new = st_r.alarm_enable_mask;
    if (req.wr && req.addr == ASMU_ADDR_MASK) begin
      mask_new = req.wdata[4:0]; // R8 R14
    end
    st_nxt.alarm_enable_mask = mask_new;
    // summary follows the updated flags; masking never touches the flags
    st_nxt.summary = |(flags_new & ~mask_new); // R9 R10
    st_nxt.pin = (status_pin_select == ASMU_PINSEL_ALARM) ? st_nxt.summary : 1'b0; // R11
    // read mux: unmapped offsets and reserved bits return zero
    st_nxt.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        ASMU_ADDR_SUMMARY: st_nxt.rdata = {7'h00, st_r.summary}; // R10
        ASMU_ADDR_FLAGS: st_nxt.rdata = {3'h0, st_r.alarm_flags}; // R12 R14
        ASMU_ADDR_MASK: st_nxt.rdata = {3'h0, st_r.alarm_enable_mask}; // R8 R14
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // flags and mask come up set; summary is therefore masked off at reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r.lock_sync <= 2'h0;
      st_r.alarm_flags <= ASMU_FLAGS_RST; // R12
      st_r.alarm_enable_mask <= ASMU_MASK_RST; // R8
      st_r.summary <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.pin <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign calibration_status_pin = st_r.pin;

  // a persisting cause cannot be cleared away
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
    set_vec[ASMU_BIT_DIV] |=> st_r.alarm_flags[ASMU_BIT_DIV])
    else $error("divider flag lost while its cause was present");

  sequence clr_flags_s;
    req.wr && req.addr == ASMU_ADDR_FLAGS && req.wdata[ASMU_BIT_REALIGN]
      && !set_vec[ASMU_BIT_REALIGN];
  endsequence

  realign_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    clr_flags_s |=> !st_r.alarm_flags[ASMU_BIT_REALIGN])
    else $error("write one did not clear realign flag");

  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    st_r.alarm_flags[ASMU_BIT_LINK] && !(req.wr && req.addr == ASMU_ADDR_FLAGS)
      |=> st_r.alarm_flags[ASMU_BIT_LINK])
    else $error("link flag dropped without a clear");

  pll_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    !st_r.lock_sync[1] |=> st_r.alarm_flags[ASMU_BIT_PLL])
    else $error("pll flag not set while unlocked");

  link_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
    cond.link_enable_ctrl && !cond.data_encoding_state |=> st_r.alarm_flags[ASMU_BIT_LINK])
    else $error("link flag not set");

  realign_set_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    cond.sysref_realign |=> st_r.alarm_flags[ASMU_BIT_REALIGN])
    else $error("realign flag not set");

  nco_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    cond.nco_sync || !cond.link_enable_ctrl |=> st_r.alarm_flags[ASMU_BIT_NCO])
    else $error("nco flag not set");

  acc_mismatch_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    cond.acc_a != cond.acc_b |=> ##1 st_r.alarm_flags[ASMU_BIT_NCO])
    else $error("accumulator mismatch not flagged within two cycles");

  div_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    cond.div_a != cond.div_b |=> st_r.alarm_flags[ASMU_BIT_DIV])
    else $error("divider mismatch not flagged");

  summary_val_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R9
    ##1 st_r.summary == |(st_r.alarm_flags & ~st_r.alarm_enable_mask))
    else $error("summary disagrees with flags and mask");

  summary_read_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    req.rd && req.addr == ASMU_ADDR_SUMMARY |=> rdata == {7'h00, $past(st_r.summary)})
    else $error("summary read wrong");

  pin_route_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    status_pin_select == ASMU_PINSEL_ALARM |=> calibration_status_pin == st_r.summary)
    else $error("status pin does not follow summary");

  mask_read_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    req.rd && req.addr == ASMU_ADDR_MASK |=> rdata[7:5] == 3'h0
      && rdata[4:0] == $past(st_r.alarm_enable_mask))
    else $error("mask read wrong");

  flags_reserved_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    req.rd && req.addr == ASMU_ADDR_FLAGS |=> rdata[7:5] == 3'h0)
    else $error("reserved flag bits not zero");

  // per-flag guards: a cause always lands, a lone clear empties, nothing rises unbidden
  genvar f;
  generate
    for (f = 0; f < ASMU_NALM; f++) begin : g_flag
      flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R13
        set_vec[f] |=> st_r.alarm_flags[f])
        else $error("flag lost while its cause was present");
      flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
        clr_vec[f] && !set_vec[f] |=> !st_r.alarm_flags[f])
        else $error("write one did not clear a flag");
      flag_cause_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R1 R2 R3 R4 R5 R6
        !st_r.alarm_flags[f] && !set_vec[f] |=> !st_r.alarm_flags[f])
        else $error("flag rose with no cause");
    end
  endgenerate

  // lock loss crosses both sync stages before it can mark the flag
  sequence unlock_seen_s;
    !cond.pll_locked;
  endsequence

  pll_sync_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    unlock_seen_s |-> ##3 st_r.alarm_flags[ASMU_BIT_PLL])
    else $error("pll unlock not flagged three cycles after the pin");

  masked_record_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R9
    cond.sysref_realign && st_r.alarm_enable_mask[ASMU_BIT_REALIGN]
      |=> st_r.alarm_flags[ASMU_BIT_REALIGN])
    else $error("masked realign flag did not record");

  mask_write_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    req.wr && req.addr == ASMU_ADDR_MASK
      |=> st_r.alarm_enable_mask == $past(req.wdata[4:0]))
    else $error("mask write did not land");

  // realign event with its mask open and no mask write racing it
  sequence realign_open_s;
    cond.sysref_realign && !st_r.alarm_enable_mask[ASMU_BIT_REALIGN]
      && !(req.wr && req.addr == ASMU_ADDR_MASK);
  endsequence

  summary_raise_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    realign_open_s |=> st_r.summary)
    else $error("unmasked realign did not raise the summary");

  pin_raise_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    realign_open_s ##0 status_pin_select == ASMU_PINSEL_ALARM |=> calibration_status_pin)
    else $error("unmasked realign did not reach the status pin");

  pin_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    status_pin_select != ASMU_PINSEL_ALARM |=> !calibration_status_pin)
    else $error("status pin driven while not selected");
endmodule

// ---- test/asmu_tb.sv ----
// asmu_tb: self-checking bench for the alarm flags, mask, summary and status pin
// assumes asmu_pkg and asmu_top are compiled first; bench drives every port itself
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module asmu_tb;
  import asmu_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  asmu_req_t req = '0;
  asmu_cond_t cond;
  logic [1:0] status_pin_select = 2'h1;
  logic [7:0] rdata;
  logic calibration_status_pin;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h9832D39F;
  logic [4:0] ef; // expected flags
  logic [4:0] em; // expected mask
  logic [7:0] d;
  logic [7:0] v;

  asmu_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .req(req), .cond(cond),
    .status_pin_select(status_pin_select), .rdata(rdata),
    .calibration_status_pin(calibration_status_pin));

  always #5 sys_clk = ~sys_clk;

  // quiet conditions: locked, link up and encoding, channels equal
  function automatic asmu_cond_t idle();
    idle = '0;
    idle.pll_locked = 1'b1;
    idle.link_enable_ctrl = 1'b1;
    idle.data_encoding_state = 1'b1;
  endfunction

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic exp_sum();
    return |(ef & ~em);
  endfunction

  // cause index to flag position
  function int bit_of(input int k);
    return (k < 3) ? 4 - k : ((k == 6) ? 0 : 1);
  endfunction

  task wr(input logic [11:0] a, input logic [7:0] w);
    @(posedge sys_clk) req <= '{1'b1, 1'b0, a, w};
    @(posedge sys_clk) req.wr <= 1'b0;
  endtask

  // rdata is registered, so it is taken one edge after the read edge
  task rd(input logic [11:0] a);
    @(posedge sys_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  // holds one alarm cause for 3 cycles; random channel data rides along
  task cause(input int k);
    asmu_cond_t c;
    int i;
    c = idle();
    for (i = 0; i < 4; i++) c.acc_a[i] = rnd();
    c.acc_b = c.acc_a;
    c.div_a = 8'(rnd());
    c.div_b = c.div_a;
    i = int'(rnd() % 4);
    case (k)
      0: c.pll_locked = 1'b0;
      1: c.data_encoding_state = 1'b0;
      2: c.sysref_realign = 1'b1;
      3: c.nco_sync = 1'b1;
      4: c.link_enable_ctrl = 1'b0;
      5: c.acc_b[i] = ~c.acc_a[i];
      default: c.div_b = ~c.div_a;
    endcase
    @(posedge sys_clk) cond <= c;
    repeat (3) @(posedge sys_clk);
    cond <= idle();
    repeat (6) @(posedge sys_clk);
    ef[bit_of(k)] = 1'b1;
  endtask

  task wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the roughly 630 cycles the sequence needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    cond = idle();
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    ef = 5'h1F;
    em = 5'h1F;
    rd(ASMU_ADDR_FLAGS); `CHK("flags rst", 8'h1F, d);
    rd(ASMU_ADDR_MASK); `CHK("mask rst", 8'h1F, d);
    rd(ASMU_ADDR_SUMMARY); `CHK("summary rst", 8'h00, d);
    repeat (4) @(posedge sys_clk);
    wr(ASMU_ADDR_FLAGS, 8'hFF);
    ef = 5'h00;
    rd(ASMU_ADDR_FLAGS); `CHK("flags clr", 8'h00, d);
    wr(ASMU_ADDR_MASK, 8'hE0);
    em = 5'h00;
    rd(ASMU_ADDR_MASK); `CHK("mask rsv", 8'h00, d);
    wr(ASMU_ADDR_SUMMARY, 8'hFF);
    rd(ASMU_ADDR_SUMMARY); `CHK("summary ro", 8'h00, d);
    rd(12'h3FF); `CHK("unmapped", 8'h00, d);
    // each cause alone sets only its own flag, which is sticky
    for (int k = 0; k < 7; k++) begin
      cause(k);
      rd(ASMU_ADDR_FLAGS); `CHK("flag set", {3'h0, ef}, d);
      `CHK("pin", 1'b1, calibration_status_pin);
      wr(ASMU_ADDR_FLAGS, 8'h00);
      rd(ASMU_ADDR_FLAGS); `CHK("flag hold", {3'h0, ef}, d);
      wr(ASMU_ADDR_FLAGS, 8'(1 << bit_of(k)));
      ef = 5'h00;
      rd(ASMU_ADDR_FLAGS); `CHK("flag w1c", 8'h00, d);
    end
    // cause and clear meet at one edge only, so only set-wins leaves the flag up
    @(posedge sys_clk) begin
      req <= '{1'b1, 1'b0, ASMU_ADDR_FLAGS, 8'h08};
      cond.data_encoding_state <= 1'b0;
    end
    @(posedge sys_clk) begin
      req.wr <= 1'b0;
      cond <= idle();
    end
    ef = 5'h08;
    rd(ASMU_ADDR_FLAGS); `CHK("set wins", 8'h08, d);
    // random masks against random causes
    for (int n = 0; n < 24; n++) begin
      v = 8'(rnd());
      wr(ASMU_ADDR_MASK, v);
      em = v[4:0];
      cause(int'(rnd() % 7));
      rd(ASMU_ADDR_SUMMARY); `CHK("summary", {7'h00, exp_sum()}, d);
      `CHK("pin sum", exp_sum(), calibration_status_pin);
      rd(ASMU_ADDR_FLAGS); `CHK("flags masked", {3'h0, ef}, d);
      wr(ASMU_ADDR_FLAGS, 8'h1F);
      ef = 5'h00;
    end
    // mid-run reset brings flags and mask back to their set state
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    ef = 5'h1F;
    em = 5'h1F;
    rd(ASMU_ADDR_MASK); `CHK("mask rst2", 8'h1F, d);
    rd(ASMU_ADDR_FLAGS); `CHK("flags rst2", 8'h1F, d);
    `CHK("pin rst2", 1'b0, calibration_status_pin);
    // pin follows the summary only when selected
    wr(ASMU_ADDR_MASK, 8'h00);
    em = 5'h00;
    cause(2);
    @(posedge sys_clk) status_pin_select <= 2'h2;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("pin off", 1'b0, calibration_status_pin);
    @(posedge sys_clk) status_pin_select <= ASMU_PINSEL_ALARM;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("pin on", 1'b1, calibration_status_pin);
    wrap_up();
  end
endmodule
